//--- phic_port.v
// Two-wire host command port with event status and receive staging FIFO
`timescale 1ns/1ps
`include "phic_consts.vh"
module phic_port (
	input wire ref_clk,
	input wire srst,
	input wire ce,
	input wire scl_in,
	input wire serial_io_pin_in,
	output reg serial_io_pin_out,
	output reg serial_io_pin_oe,
	output wire event_out,
	input wire deferred_mode,
	input wire tx_go_in,
	input wire [7:0] rx_data,
	input wire rx_valid,
	input wire rx_frame_end,
	input wire rx_null_frame,
	input wire rx_overflow,
	input wire [10:0] tx_count,
	input wire [10:0] tx_high_thr,
	input wire [10:0] tx_low_thr,
	input wire [7:0] rx_thr,
	input wire tx_overflow,
	output reg [7:0] tx_data,
	output reg tx_data_valid,
	output reg frame_open,
	output reg [1:0] codec_sel,
	output reg frame_send,
	output reg frame_close,
	output reg reg_wr,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata,
	input wire [7:0] reg_rdata
);
	// ----------------------------------------
	// Phase and command codes
	// ----------------------------------------
	localparam PH_IDLE = 3'd0;
	localparam PH_ADDR = 3'd1;
	localparam PH_CMD = 3'd2;
	localparam PH_ARG = 3'd3;
	localparam PH_DATA = 3'd4;
	localparam PH_RD = 3'd5;
	localparam PH_WAIT = 3'd6;
	localparam RC_NONE = 2'd0;
	localparam RC_EVT = 2'd1;
	localparam RC_FLT = 2'd2;
	localparam RC_REG = 2'd3;

	// Open-frame decode, used for command checks and codec choice
	function is_open;
		input [7:0] b;
		begin
			is_open = (b == `PHIC_CMD_OPEN0) | (b == `PHIC_CMD_OPEN1) |
				(b == `PHIC_CMD_OPEN2) | (b == `PHIC_CMD_OPEN3);
		end
	endfunction

	reg [2:0] scl_s_q;
	reg [2:0] sda_s_q;
	reg [2:0] go_s_q;
	reg [2:0] ph_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg [7:0] cmd_q;
	reg [1:0] rcmd_q;
	reg [1:0] wr_idx_q;
	reg reading_q;
	reg ack_slot_q;
	reg [7:0] out_q;
	reg [7:0] en_q;
	reg [7:0] st_q;
	reg [2:0] flt_q;
	reg [7:0] cond_q;
	reg pin_q;
	reg defer_q;
	reg fetch_evt_q;
	reg fetch_flt_q;
	reg got_data_q;
	reg rx_frame_q;
	reg ill_cmd;
	wire scl;
	wire sda;
	wire scl_rise;
	wire scl_fall;
	wire start_c;
	wire stop_c;
	wire go_tog;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire [3:0] fifo_cnt;
	reg fifo_pop;
	reg fifo_frame_pop;
	wire [7:0] cond;
	wire [7:0] rise;
	wire [7:0] status;

	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	// Third stage only feeds edge detectors, first stage read by nothing else
	always @(posedge ref_clk) begin
		if (srst) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			go_s_q <= 3'h0;
		end else if (ce) begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], serial_io_pin_in};
			go_s_q <= {go_s_q[1:0], tx_go_in};
		end
	end
	assign scl = scl_s_q[1];
	assign sda = sda_s_q[1];
	assign scl_rise = scl & ~scl_s_q[2];
	assign scl_fall = ~scl & scl_s_q[2];
	assign start_c = scl & scl_s_q[2] & ~sda & sda_s_q[2];
	assign stop_c = scl & scl_s_q[2] & sda & ~sda_s_q[2];
	assign go_tog = go_s_q[1] ^ go_s_q[2];

	// ----------------------------------------
	// Receive staging FIFO toward the host
	// ----------------------------------------
	phic_fifo #(
		.WIDTH(`PHIC_FIFO_W),
		.DEPTH(`PHIC_FIFO_D),
		.AW(`PHIC_FIFO_AW)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.in_valid(rx_valid),
		.in_ready(fifo_in_ready),
		.in_data(rx_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.count(fifo_cnt)
	);

	// ----------------------------------------
	// Event conditions and sticky status
	// ----------------------------------------
	// Live conditions; a rising edge fires the event once only
	assign cond[`PHIC_ST_TXHIGH] = (tx_count >= tx_high_thr);
	assign cond[`PHIC_ST_TXLOW] = (tx_count <= tx_low_thr);
	assign cond[`PHIC_ST_RXLVL] = ({4'h0, fifo_cnt} >= rx_thr) & (rx_thr != 8'h00);
	assign cond[`PHIC_ST_FRAME] = rx_frame_end & rx_valid & fifo_in_ready;
	assign cond[`PHIC_ST_EMPTY] = ~fifo_out_valid;
	assign cond[`PHIC_ST_DRAIN] = fifo_frame_pop;
	assign cond[`PHIC_ST_NULL] = rx_null_frame;
	assign cond[`PHIC_ST_FAULT] = |flt_q;
	assign rise = cond & ~cond_q;
	// Empty bit reads live; the rest are sticky
	assign status = {st_q[7:5], cond[`PHIC_ST_EMPTY], st_q[3:0]};
	assign event_out = pin_q;

	// Status, fault byte and pin; set wins over clear
	always @(posedge ref_clk) begin
		if (srst) begin
			cond_q <= `PHIC_COND_RESET;
			st_q <= 8'h00;
			flt_q <= 3'h0;
			pin_q <= 1'b0;
			en_q <= `PHIC_EN_RESET;
			rx_frame_q <= 1'b0;
		end else if (ce) begin
			cond_q <= cond;
			if (rx_valid & fifo_in_ready & rx_frame_end)
				rx_frame_q <= 1'b1;
			else if (fifo_frame_pop)
				rx_frame_q <= 1'b0;
			// Fault byte clears on fetch, new faults still land
			flt_q <= (fetch_flt_q ? 3'h0 : flt_q) |
				{ill_cmd, tx_overflow, rx_overflow | (rx_valid & ~fifo_in_ready)};
			if (fetch_evt_q)
				st_q <= {st_q[7] & ~fetch_flt_q, 7'h00} | (rise & en_q);
			else if (fetch_flt_q)
				st_q <= {1'b0, st_q[6:0]} | (rise & en_q);
			else
				st_q <= st_q | (rise & en_q);
			if (|(rise & en_q))
				pin_q <= 1'b1;
			else if (fetch_evt_q | fetch_flt_q)
				pin_q <= 1'b0;
			if (reg_wr & (reg_addr == `PHIC_REG_EVT_EN))
				en_q <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Serial byte engine and command decode
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (srst) begin
			ph_q <= PH_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			cmd_q <= 8'h00;
			rcmd_q <= RC_NONE;
			wr_idx_q <= 2'd0;
			reading_q <= 1'b0;
			ack_slot_q <= 1'b0;
			out_q <= `PHIC_DUMMY;
			serial_io_pin_out <= 1'b0;
			serial_io_pin_oe <= 1'b0;
			fetch_evt_q <= 1'b0;
			fetch_flt_q <= 1'b0;
			ill_cmd <= 1'b0;
			fifo_pop <= 1'b0;
			fifo_frame_pop <= 1'b0;
			tx_data <= 8'h00;
			tx_data_valid <= 1'b0;
			frame_open <= 1'b0;
			codec_sel <= 2'd0;
			frame_send <= 1'b0;
			frame_close <= 1'b0;
			defer_q <= 1'b0;
			got_data_q <= 1'b0;
			reg_wr <= 1'b0;
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
		end else if (ce) begin
			fetch_evt_q <= 1'b0;
			fetch_flt_q <= 1'b0;
			ill_cmd <= 1'b0;
			fifo_pop <= 1'b0;
			fifo_frame_pop <= 1'b0;
			tx_data_valid <= 1'b0;
			frame_close <= 1'b0;
			reg_wr <= 1'b0;
			// Deferred start waits for the go toggle
			if (defer_q & go_tog) begin
				defer_q <= 1'b0;
				frame_send <= 1'b1;
			end
			if (start_c) begin
				// Restart keeps the pending read command
				ph_q <= PH_ADDR;
				bit_q <= 4'h0;
				serial_io_pin_oe <= 1'b0;
				reading_q <= 1'b0;
				ack_slot_q <= 1'b0;
			end else if (stop_c) begin
				ph_q <= PH_IDLE;
				serial_io_pin_oe <= 1'b0;
				if (rcmd_q == RC_EVT)
					fetch_evt_q <= reading_q;
				if (rcmd_q == RC_FLT)
					fetch_flt_q <= reading_q;
				rcmd_q <= RC_NONE;
				reading_q <= 1'b0;
			end else if (scl_rise & (ph_q != PH_IDLE) & (ph_q != PH_WAIT)) begin
				if (ack_slot_q) begin
					// Host not-acknowledge ends a read
					if (ph_q == PH_RD & sda) begin
						ph_q <= PH_WAIT;
						if (rcmd_q == RC_EVT)
							fetch_evt_q <= 1'b1;
						if (rcmd_q == RC_FLT)
							fetch_flt_q <= 1'b1;
						rcmd_q <= RC_NONE;
					end
				end else begin
					sh_q <= (ph_q == PH_RD) ? sh_q : {sh_q[6:0], sda};
					bit_q <= bit_q + 4'h1;
				end
			end else if (scl_fall & (ph_q != PH_IDLE) & (ph_q != PH_WAIT)) begin
				if (ack_slot_q) begin
					// Leave ack slot; load next outgoing byte
					ack_slot_q <= 1'b0;
					bit_q <= 4'h0;
					serial_io_pin_oe <= 1'b0;
					if (ph_q == PH_RD) begin
						serial_io_pin_oe <= ~out_q[7];
						serial_io_pin_out <= 1'b0;
						sh_q <= {out_q[6:0], 1'b0};
					end
				end else if (ph_q == PH_RD & bit_q != 4'h8) begin
					serial_io_pin_oe <= ~sh_q[7];
					sh_q <= {sh_q[6:0], 1'b0};
				end else if (bit_q == 4'h8) begin
					ack_slot_q <= 1'b1;
					serial_io_pin_oe <= 1'b0;
					case (ph_q)
					PH_ADDR: begin
						if (sh_q == `PHIC_ADDR_WR) begin
							serial_io_pin_oe <= 1'b1;
							ph_q <= PH_CMD;
							wr_idx_q <= 2'd0;
						end else if (sh_q == `PHIC_ADDR_RD) begin
							serial_io_pin_oe <= 1'b1;
							ph_q <= PH_RD;
							reading_q <= 1'b1;
							// No pending command means a bare data fetch
							case (rcmd_q)
							RC_EVT: out_q <= status;
							RC_FLT: out_q <= {4'h0, flt_q, 1'b0};
							RC_REG: out_q <= reg_rdata;
							default: begin
								out_q <= fifo_out_valid ? fifo_out_data : `PHIC_DUMMY;
								fifo_pop <= fifo_out_valid;
								fifo_frame_pop <= fifo_out_valid & (fifo_cnt == 4'h1) &
									rx_frame_q;
							end
							endcase
						end else
							ph_q <= PH_WAIT;
					end
					PH_CMD: begin
						serial_io_pin_oe <= 1'b1;
						cmd_q <= sh_q;
						ph_q <= PH_DATA;
						if (is_open(sh_q)) begin
							codec_sel <= sh_q[5:4];
							frame_open <= 1'b1;
							got_data_q <= 1'b0;
							frame_send <= ~deferred_mode;
							defer_q <= deferred_mode;
						end else if (sh_q == `PHIC_CMD_CLOSE) begin
							frame_open <= 1'b0;
							frame_close <= 1'b1;
							frame_send <= 1'b0;
						end else if (sh_q == `PHIC_CMD_WREG | sh_q == `PHIC_CMD_RREG)
							ph_q <= PH_ARG;
						else if (sh_q == `PHIC_CMD_EVT)
							rcmd_q <= RC_EVT;
						else if (sh_q == `PHIC_CMD_FLT)
							rcmd_q <= RC_FLT;
						else begin
							serial_io_pin_oe <= 1'b0;
							ill_cmd <= 1'b1;
							ph_q <= PH_WAIT;
						end
					end
					PH_ARG: begin
						serial_io_pin_oe <= 1'b1;
						if (wr_idx_q == 2'd0) begin
							reg_addr <= sh_q;
							wr_idx_q <= 2'd1;
							if (cmd_q == `PHIC_CMD_RREG) begin
								rcmd_q <= RC_REG;
								ph_q <= PH_DATA;
							end
						end else begin
							reg_wdata <= sh_q;
							reg_wr <= 1'b1;
							ph_q <= PH_DATA;
						end
					end
					PH_DATA: begin
						// Payload bytes belong to an open frame only
						serial_io_pin_oe <= is_open(cmd_q);
						if (is_open(cmd_q)) begin
							tx_data <= sh_q;
							tx_data_valid <= 1'b1;
							got_data_q <= 1'b1;
						end
					end
					PH_RD: ph_q <= PH_RD;
					default: ph_q <= PH_WAIT;
					endcase
				end
			end
		end
	end
endmodule

//--- phic_consts.vh
// Constants of the host serial command port
`ifndef PHIC_CONSTS_VH
`define PHIC_CONSTS_VH
// Bus addresses (8-bit form with direction bit)
`define PHIC_ADDR_WR 8'h44
`define PHIC_ADDR_RD 8'h45
// Command bytes
`define PHIC_CMD_OPEN0 8'h04
`define PHIC_CMD_OPEN1 8'h14
`define PHIC_CMD_OPEN2 8'h24
`define PHIC_CMD_OPEN3 8'h34
`define PHIC_CMD_CLOSE 8'h0F
`define PHIC_CMD_WREG 8'hF5
`define PHIC_CMD_RREG 8'hFD
`define PHIC_CMD_EVT 8'h01
`define PHIC_CMD_FLT 8'h11
// Status byte bit positions
`define PHIC_ST_FAULT 7
`define PHIC_ST_NULL 6
`define PHIC_ST_DRAIN 5
`define PHIC_ST_EMPTY 4
`define PHIC_ST_RXLVL 3
`define PHIC_ST_FRAME 2
`define PHIC_ST_TXLOW 1
`define PHIC_ST_TXHIGH 0
// Fault byte bit positions
`define PHIC_FLT_RXOVF 1
`define PHIC_FLT_TXOVF 2
`define PHIC_FLT_ILL 3
// Reset values
`define PHIC_EN_RESET 8'hBF
`define PHIC_DUMMY 8'hFF
// Condition history starts at the idle picture: receive FIFO empty
`define PHIC_COND_RESET 8'h10
// Register address of the event enable byte
`define PHIC_REG_EVT_EN 8'h04
// Serial clock limit (ns) and minimum clock cycles per half period
`define PHIC_SCL_MIN_PERIOD_NS 1000
`define PHIC_CLK_PERIOD_NS 10
`define PHIC_HALF_CYC ((`PHIC_SCL_MIN_PERIOD_NS / 2) / `PHIC_CLK_PERIOD_NS)
// FIFO shape
`define PHIC_FIFO_W 8
`define PHIC_FIFO_D 8
`define PHIC_FIFO_AW 3
`endif

//--- phic_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module phic_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire ref_clk,
	input wire srst,
	input wire ce,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data,
	output wire [AW:0] count
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;
	assign count = cnt_q;

	// Storage and pointers; head word kept in a register
	always @(posedge ref_clk) begin
		if (srst) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_q[wp_q] <= in_data;
				wp_q <= wp_q + 1'b1;
			end
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Registered read port shows the word at the head
	always @(posedge ref_clk) begin
		if (srst)
			out_data <= {WIDTH{1'b0}};
		else if (ce)
			out_data <= mem_q[pop ? rp_q + 1'b1 : rp_q];
	end
endmodule

//--- phic_host_model.sv
// Host controller model: two-wire bus master with an open-drain data line
`timescale 1ns/1ps
module phic_host_model (
	input wire logic ref_clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// Clock idles high, data released between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// ----------------------------------------
	// Quarter bit of 25 cycles keeps the clock at 1 MHz
	// ----------------------------------------
	task automatic q();
		repeat (25) @(posedge ref_clk);
		#1;
	endtask
	// Data falls while clock is high
	task automatic start();
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
	endtask
	task automatic rstart();
		q();
		sda_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
	endtask
	// Data rises while clock is high, bus left idle
	task automatic stop();
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask
	// Change while clock low, sample while high
	task automatic bit_x(input logic b, output logic s);
		q();
		sda_low = !b;
		q();
		scl = 1'b1;
		q();
		s = sda;
		q();
		scl = 1'b0;
	endtask
	// Most significant bit first, then the answer slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(nack, s);
	endtask
endmodule

//--- phic_port_assertions.sv
// Concurrent checks on the pins of the host command port
`timescale 1ns/1ps
module phic_port_assertions (
	input wire ref_clk,
	input wire srst,
	input wire scl_in,
	input wire serial_io_pin_out,
	input wire serial_io_pin_oe,
	input wire event_out,
	input wire deferred_mode,
	input wire frame_open,
	input wire frame_send,
	input wire frame_close,
	input wire [1:0] codec_sel,
	input wire reg_wr,
	input wire tx_data_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Fresh frame in normal mode, and a frame holding the channel
	sequence open_s;
		$rose(frame_open) && !deferred_mode;
	endsequence
	sequence busy_s;
		frame_open && frame_send;
	endsequence
	drain_low_a: assert property (!serial_io_pin_out)
		else $error("data pin driven high");
	oe_move_a: assert property ($changed(serial_io_pin_oe) |-> !scl_in)
		else $error("data changed while clock high");
	close_pulse_a: assert property (frame_close |=> !frame_close)
		else $error("close pulse too long");
	close_ends_a: assert property (frame_close |-> ##[0:2] !frame_open)
		else $error("frame stayed open after close");
	send_now_a: assert property (open_s |-> ##[0:2] frame_send)
		else $error("normal frame not sent");
	send_wait_a: assert property ($rose(frame_open) && deferred_mode |=> !frame_send)
		else $error("deferred frame sent early");
	occupy_a: assert property (busy_s |=> frame_send || !frame_open)
		else $error("open frame left the channel");
	codec_hold_a: assert property (frame_open && $past(frame_open) |-> $stable(codec_sel))
		else $error("codec moved in a frame");
	wr_pulse_a: assert property (reg_wr |=> !reg_wr)
		else $error("register write pulse too long");
	byte_pulse_a: assert property (tx_data_valid |=> !tx_data_valid)
		else $error("payload pulse too long");
	ev_clear_a: assert property ($fell(event_out) |-> scl_in)
		else $error("event pin dropped mid byte");
endmodule
bind phic_port phic_port_assertions u_chk (.ref_clk, .srst, .scl_in, .serial_io_pin_out,
	.serial_io_pin_oe, .event_out, .deferred_mode, .frame_open, .frame_send,
	.frame_close, .codec_sel, .reg_wr, .tx_data_valid);

//--- phic_port_tb_top.sv
// Self-checking bench for the host command port
`timescale 1ns/1ps
`include "phic_consts.vh"
module phic_port_tb_top;
	logic ref_clk, srst, h_low, scl, oe, sio_out, event_out, ack, deferred_mode, tx_go_in;
	logic rx_valid, rx_frame_end, rx_null_frame, rx_overflow, tx_overflow, tx_data_valid, frame_open;
	logic frame_send, frame_close, reg_wr;
	logic [1:0] codec_sel, cc;
	logic [7:0] rx_data, tx_data, reg_addr, reg_wdata, reg_rdata, rd;
	logic [10:0] tx_count;
	wire sda;
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	// Pulled-up wire, low while either side pulls it
	assign sda = !(h_low || oe);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = !ref_clk;
	end
	phic_port u_dut (.ref_clk, .srst, .ce(1'b1), .scl_in(scl), .serial_io_pin_in(sda),
		.serial_io_pin_out(sio_out), .serial_io_pin_oe(oe), .event_out, .deferred_mode,
		.tx_go_in, .rx_data, .rx_valid, .rx_frame_end, .rx_null_frame, .rx_overflow,
		.tx_count, .tx_high_thr(11'h080), .tx_low_thr(11'h008), .rx_thr(8'h03),
		.tx_overflow, .tx_data, .tx_data_valid, .frame_open, .codec_sel, .frame_send,
		.frame_close, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
	phic_host_model u_host (.ref_clk, .scl, .sda_low(h_low), .sda);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic wb(input logic [7:0] d, input logic e = 1'b1);
		u_host.wbyte(d, ack);
		check("ack", 8'(ack), 8'(e));
	endtask
	task automatic wr(input logic [7:0] c);
		u_host.start();
		wb(`PHIC_ADDR_WR);
		wb(c);
		u_host.stop();
	endtask
	// Command, optional address byte, restart and one read byte
	task automatic fetch(input logic [7:0] c, input logic [7:0] a = 8'h00, input bit na = 0);
		u_host.start();
		wb(`PHIC_ADDR_WR);
		wb(c);
		if (na) wb(a);
		u_host.rstart();
		wb(`PHIC_ADDR_RD);
		u_host.rbyte(1'b1, rd);
		u_host.stop();
	endtask
	task automatic pop();
		u_host.start();
		wb(`PHIC_ADDR_RD);
		u_host.rbyte(1'b1, rd);
		u_host.stop();
	endtask
	task automatic push(input logic [7:0] d, input logic last);
		tick();
		rx_data = d;
		rx_valid = 1'b1;
		rx_frame_end = last;
		tick();
		rx_valid = 1'b0;
		rx_frame_end = 1'b0;
	endtask
	// Settle time covers the pin's synchroniser lag
	task automatic ev_is(input logic e);
		repeat (30) tick();
		check("event_out", 8'(event_out), 8'(e));
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Hang guard, sized above the longest expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			err_total++;
			results();
		end
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{srst, deferred_mode, tx_go_in, rx_valid, rx_frame_end} = 5'h10;
		{rx_null_frame, tx_overflow, rx_overflow, rx_data, reg_rdata} = 19'h00000;
		tx_count = 11'h010;
		repeat (5) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (5) tick();
		ev_is(1'b0);
		fetch(`PHIC_CMD_EVT);
		ev_is(1'b0);
		#1 tx_count = 11'h100;
		ev_is(1'b1);
		fetch(`PHIC_CMD_EVT);
		check("status", rd, 8'h11);
		ev_is(1'b0);
		$display("levels test done");
		for (int i = 0; i < 2; i++) begin
			tick();
			rx_null_frame = 1'b1;
			tick();
			rx_null_frame = 1'b0;
			ev_is(i[0]);
			if (i == 0) begin
				u_host.start();
				wb(`PHIC_ADDR_WR);
				wb(`PHIC_CMD_WREG);
				wb(`PHIC_REG_EVT_EN);
				wb(8'hFF);
				u_host.stop();
			end
		end
		check("reg_wdata", reg_wdata, 8'hFF);
		fetch(`PHIC_CMD_EVT);
		check("status", rd, 8'h50);
		reg_rdata = 8'h5A;
		fetch(`PHIC_CMD_RREG, 8'h07, 1'b1);
		check("reg_read", rd, 8'h5A);
		check("reg_addr", reg_addr, 8'h07);
		$display("register test done");
		for (int c = 0; c < 4; c++) begin
			cc = c[1:0];
			u_host.start();
			wb(`PHIC_ADDR_WR);
			wb({2'b00, cc, 4'h4});
			wb(8'hC3);
			u_host.stop();
			check("codec", 8'(codec_sel), 8'(cc));
			check("sending", 8'(frame_send), 8'h01);
			check("tx_data", tx_data, 8'hC3);
			wr(`PHIC_CMD_CLOSE);
			check("open", 8'(frame_open), 8'h00);
		end
		deferred_mode = 1'b1;
		wr(`PHIC_CMD_OPEN0);
		check("held", 8'(frame_send), 8'h00);
		tx_go_in = 1'b1;
		ev_is(1'b0);
		check("released", 8'(frame_send), 8'h01);
		wr(`PHIC_CMD_CLOSE);
		deferred_mode = 1'b0;
		$display("frame test done");
		push(8'h11, 1'b0);
		push(8'h22, 1'b0);
		push(8'h33, 1'b1);
		ev_is(1'b1);
		fetch(`PHIC_CMD_EVT);
		check("status", rd, 8'h0C);
		for (int i = 1; i < 4; i++) begin
			pop();
			check("rx_byte", rd, 8'(8'h11 * i));
		end
		ev_is(1'b1);
		fetch(`PHIC_CMD_EVT);
		check("status", rd, 8'h30);
		pop();
		check("dummy", rd, `PHIC_DUMMY);
		$display("receive test done");
		for (int i = 0; i < 9; i++) push(8'(i), 1'b0);
		u_host.start();
		wb(`PHIC_ADDR_WR);
		wb(8'h77, 1'b0);
		u_host.stop();
		u_host.start();
		wb(8'h50, 1'b0);
		u_host.stop();
		tx_overflow = 1'b1;
		tick();
		tx_overflow = 1'b0;
		ev_is(1'b1);
		fetch(`PHIC_CMD_EVT);
		check("fault_flag", 8'(rd[7]), 8'h01);
		ev_is(1'b0);
		fetch(`PHIC_CMD_FLT);
		check("fault", rd, 8'h0E);
		ev_is(1'b0);
		fetch(`PHIC_CMD_EVT);
		check("fault_flag", 8'(rd[7]), 8'h00);
		// Outside receive overflow alone, with the transmit level dropping low
		tx_count = 11'h004;
		rx_overflow = 1'b1;
		tick();
		rx_overflow = 1'b0;
		ev_is(1'b1);
		fetch(`PHIC_CMD_EVT);
		check("status", rd, 8'h82);
		fetch(`PHIC_CMD_FLT);
		check("fault", rd, 8'h02);
		ev_is(1'b0);
		$display("fault test done");
		results();
	end
endmodule
